// ==== gcs_top.sv ====
// What this block does
// RL1 - Select one pin is active low when its polarity bit is 0, else high.
// RL2 - Select one asserts during E high, or whole address-valid time when valid bit set.
// RL3 - Select two pin is active low when its polarity bit is 0, else high.
// RL4 - Select two asserts during E high, or whole address-valid time when valid bit set.
// RL5 - Size 0 disables, 1..9 give 2K..512K, 10/11 follow windows, 12..15 act as 512K.
// RL6 - Only start-address bits valid for the size and basing are compared; the code also compares bit 11 for a CPU-based 4K select.
// RL7 - All eight routing bit combinations give defined pin outputs.
// RL8 - Route-one-to-two ORs select one into the select two pin.
// RL9 - Route-one-to-program ORs select one into the program pin.
// RL10 - Route-two-to-program ORs select two into the program pin.
// RL11 - A routed select never drives its own pin; one-to-two yields when two is routed.
// RL12 - Program versus general priority still applies while routing.
// RL13 - All select outputs change in step with the E clock.
// RL14 - E holds high for the winning select's extra cycles, only inside its range.
// RL15 - Timer clock keeps running during a stretch.
// RL16 - Each select has a 2-bit binary stretch count, zero to three.
// RL17 - Priority bit 1 lets general selects win over program select, 0 the reverse.
// RL18 - Basing bit 0 decodes the CPU address, 1 the expansion address.
// RL19 - Follow-window mode asserts on the window hit, ignoring expanded lines.
// RL20 - A select matches when all compared bits equal and size is nonzero.
// RL21 - After reset all control fields read zero: selects disabled, no stretching.
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps

module gcs_top
  import gcs_pkg::*;
(
  // Clock and reset
  input  wire logic                   CLK_SYS_I,
  input  wire logic                   SRST_I,
  // Avalon-MM register slave
  input  wire logic [GCS_ADDR_W-1:0]  AVS_ADDRESS_I,
  input  wire logic                   AVS_READ_I,
  input  wire logic                   AVS_WRITE_I,
  input  wire logic [31:0]            AVS_WRITEDATA_I,
  output logic      [31:0]            AVS_READDATA_O,
  output logic                        AVS_WAITREQUEST_O,
  // CPU bus and outside decoders
  input  wire logic                   BUS_ACCESS_I,
  input  wire gcs_decode_t            DECODE_I,
  // Expansion bus outputs
  output logic                        E_CLK_O,
  output logic                        TIMER_CLK_O,
  output logic                        STRETCHING_O,
  output logic                        PROGRAM_SELECT_PIN_O,
  output logic                        GENERAL_SELECT_ONE_PIN_O,
  output logic                        GENERAL_SELECT_TWO_PIN_O
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic sel_match(
    input logic [3:0]             size,
    input logic [7:0]             base,
    input logic                   exp_basing,
    input logic [15:0]            cpu_addr,
    input logic [GCS_XADDR_W-1:0] exp_addr,
    input logic                   win1,
    input logic                   win2
  );
    logic [GCS_XADDR_W-1:0] addr;
    logic [3:0]             eff;
    logic                   hit;
    int                     lo;
    addr = exp_basing ? exp_addr : {3'h0, cpu_addr};                     // [RL18]
    eff  = (size > GCS_SZ_WIN2) ? GCS_SZ_512K : size;                    // [RL5]
    lo   = GCS_SZ_SHIFT + int'(eff);
    if (!exp_basing && eff == GCS_SZ_4K) begin
      lo = GCS_BASE_LSB;                                                 // [RL6]
    end
    hit = 1'b1;
    for (int i = GCS_BASE_LSB; i < GCS_XADDR_W; i++) begin
      if (i >= lo && (exp_basing || i <= GCS_CPU_MSB)) begin
        if (addr[i] != base[i-GCS_BASE_LSB]) begin
          hit = 1'b0;                                                    // [RL6] [RL20]
        end
      end
    end
    if (size == GCS_SZ_OFF) begin
      sel_match = 1'b0;                                                  // [RL5] [RL20]
    end else if (size == GCS_SZ_WIN1) begin
      sel_match = win1;                                                  // [RL19]
    end else if (size == GCS_SZ_WIN2) begin
      sel_match = win2;                                                  // [RL19]
    end else begin
      sel_match = hit;
    end
  endfunction : sel_match

  // Polarity bit 1 means active high, so the pin level is active XNOR the polarity bit
  function automatic logic pin_level(input logic active, input logic pol);
    pin_level = pol ? active : ~active;
  endfunction : pin_level

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  gcs_state_t st_reg;
  gcs_state_t st_next;

  logic [8:0] reg_idx;
  logic       req;
  logic       valid_slot;
  logic       one_hit;
  logic       two_hit;
  logic       one_win;
  logic       two_win;
  logic       prog_win;
  logic       one_act;
  logic       two_act;
  logic       one_to_two;
  logic [1:0] extra_cycles;
  logic       e_high_next;
  logic       cycle_next;
  logic       e_edge;
  logic       e_fall;
  logic [7:0] rd_byte;

  assign reg_idx = AVS_ADDRESS_I[GCS_ADDR_W-1:2];
  assign req     = AVS_READ_I | AVS_WRITE_I;

  always_comb begin
    st_next = st_reg;

    // --------------------------------------------------------------
    // Register slave: one wait state, then the answer
    // --------------------------------------------------------------
    st_next.waitreq = ~(req & st_reg.waitreq);
    rd_byte = 8'h00;
    case (reg_idx)
      GCS_IDX_STRETCH:  rd_byte = st_reg.stretch_cfg;
      GCS_IDX_ONE_BASE: rd_byte = st_reg.one_base;
      GCS_IDX_ONE_CTRL: rd_byte = st_reg.one_ctrl;
      GCS_IDX_TWO_BASE: rd_byte = st_reg.two_base;
      GCS_IDX_TWO_CTRL: rd_byte = {st_reg.two_ctrl[7], 1'b0, st_reg.two_ctrl[5:0]};
      GCS_IDX_STATUS:   rd_byte = {3'h0, st_reg.stretching, st_reg.e_clk,
                                   st_reg.program_select_pin,
                                   st_reg.general_select_two_pin,
                                   st_reg.general_select_one_pin};
      default:          rd_byte = 8'h00;
    endcase
    if (AVS_READ_I && st_reg.waitreq) begin
      st_next.rdata = {24'h000000, rd_byte};
    end
    if (AVS_WRITE_I && !st_reg.waitreq && AVS_ADDRESS_I[1:0] == 2'b00) begin
      case (reg_idx)
        GCS_IDX_STRETCH:  st_next.stretch_cfg = AVS_WRITEDATA_I[7:0];
        GCS_IDX_ONE_BASE: st_next.one_base    = AVS_WRITEDATA_I[7:0];
        GCS_IDX_ONE_CTRL: st_next.one_ctrl    = AVS_WRITEDATA_I[7:0];
        GCS_IDX_TWO_BASE: st_next.two_base    = AVS_WRITEDATA_I[7:0];
        GCS_IDX_TWO_CTRL: st_next.two_ctrl    = AVS_WRITEDATA_I[7:0];
        default:          st_next.rdata       = st_reg.rdata;
      endcase
    end

    // --------------------------------------------------------------
    // E clock sequencing
    // --------------------------------------------------------------
    // The timer clock is a free divider and never sees the stretch
    st_next.timer_clk = ~st_reg.timer_clk;                               // [RL15]
    cycle_next  = st_reg.cycle_on;
    e_high_next = st_reg.e_clk;
    case (st_reg.phase)
      GCS_PH_LOW: begin
        st_next.phase = GCS_PH_HIGH;
        e_high_next   = 1'b1;
        cycle_next    = st_reg.cycle_on;
      end
      GCS_PH_HIGH: begin
        if (st_reg.hold_cnt != 3'h0) begin
          st_next.hold_cnt = st_reg.hold_cnt - 3'h1;                     // [RL14]
          e_high_next      = 1'b1;
        end else begin
          st_next.phase = GCS_PH_LOW;
          e_high_next   = 1'b0;
          cycle_next    = BUS_ACCESS_I;
        end
      end
      default: begin
        st_next.phase = GCS_PH_LOW;
        e_high_next   = 1'b0;
        cycle_next    = 1'b0;
      end
    endcase
    st_next.e_clk    = e_high_next;
    st_next.cycle_on = cycle_next;
    // Pins may only move on an E transition, so mid-cycle writes wait for the next edge
    e_edge = e_high_next ^ st_reg.e_clk;                                 // [RL13]
    e_fall = st_reg.e_clk & ~e_high_next;                                // [RL13]

    // --------------------------------------------------------------
    // Decode, priority and routing
    // --------------------------------------------------------------
    one_hit = cycle_next & sel_match(st_reg.one_ctrl[GCS_CTRL_SIZE_HI:0], st_reg.one_base,
                                     DECODE_I.sel_one_expansion_basing, DECODE_I.cpu_addr,
                                     DECODE_I.exp_addr, DECODE_I.win_one_hit,
                                     DECODE_I.win_two_hit);
    two_hit = cycle_next & sel_match(st_reg.two_ctrl[GCS_CTRL_SIZE_HI:0], st_reg.two_base,
                                     DECODE_I.sel_two_expansion_basing, DECODE_I.cpu_addr,
                                     DECODE_I.exp_addr, DECODE_I.win_one_hit,
                                     DECODE_I.win_two_hit);
    if (DECODE_I.general_over_program_priority) begin                    // [RL17] [RL12]
      one_win  = one_hit;
      two_win  = two_hit;
      prog_win = cycle_next & DECODE_I.program_hit & ~(one_hit | two_hit);
    end else begin
      prog_win = cycle_next & DECODE_I.program_hit;
      one_win  = one_hit & ~prog_win;
      two_win  = two_hit & ~prog_win;
    end

    // Valid time: address valid spans the whole cycle, otherwise E high only
    one_act = one_win & (st_reg.one_ctrl[GCS_CTRL_VALID] | e_high_next);  // [RL2]
    two_act = two_win & (st_reg.two_ctrl[GCS_CTRL_VALID] | e_high_next);  // [RL4]

    // One-to-two only works when neither select is sent to the program pin
    one_to_two = st_reg.one_ctrl[GCS_CTRL_TO_TWO] & ~st_reg.one_ctrl[GCS_CTRL_TO_PROG]
               & ~st_reg.two_ctrl[GCS_CTRL_TO_PROG];                     // [RL11] [RL7]

    if (e_edge) begin
      st_next.general_select_one_pin = pin_level(
        one_act & ~st_reg.one_ctrl[GCS_CTRL_TO_PROG] & ~one_to_two,      // [RL11]
        st_reg.one_ctrl[GCS_CTRL_POL]);                                  // [RL1] [RL13]
      st_next.general_select_two_pin = pin_level(
        ~st_reg.two_ctrl[GCS_CTRL_TO_PROG] & (two_act | (one_to_two & one_act)), // [RL8]
        st_reg.two_ctrl[GCS_CTRL_POL]);                                  // [RL3] [RL13]
    end
    // Program select is fixed active low at address-valid timing; routed selects inherit it
    if (e_fall) begin
      st_next.program_select_pin = ~(prog_win
        | (st_reg.one_ctrl[GCS_CTRL_TO_PROG] & one_win)                  // [RL9]
        | (st_reg.two_ctrl[GCS_CTRL_TO_PROG] & two_win));                // [RL10] [RL13]
    end

    // --------------------------------------------------------------
    // Stretch count of the select that owns the access
    // --------------------------------------------------------------
    if (prog_win) begin
      extra_cycles = st_reg.stretch_cfg[GCS_STR_PROG_LO +: 2];           // [RL16]
    end else if (one_win) begin
      extra_cycles = st_reg.stretch_cfg[GCS_STR_ONE_LO +: 2];            // [RL16]
    end else if (two_win) begin
      extra_cycles = st_reg.stretch_cfg[GCS_STR_TWO_LO +: 2];            // [RL16]
    end else if (cycle_next && DECODE_I.io_hit) begin
      extra_cycles = st_reg.stretch_cfg[GCS_STR_IO_LO +: 2];             // [RL16]
    end else begin
      extra_cycles = 2'b00;                                              // [RL14]
    end
    // Each extra bus cycle keeps E high for one more low and high slot
    if (st_reg.phase == GCS_PH_LOW) begin
      st_next.hold_cnt = {extra_cycles, 1'b0};                           // [RL14]
    end
    valid_slot = (st_reg.phase == GCS_PH_HIGH) && (st_reg.hold_cnt != 3'h0);
    st_next.stretching = valid_slot;

    // --------------------------------------------------------------
    // Reset
    // --------------------------------------------------------------
    if (SRST_I) begin
      st_next.phase                  = GCS_PH_LOW;
      st_next.hold_cnt               = 3'h0;
      st_next.cycle_on               = 1'b0;
      st_next.e_clk                  = 1'b0;
      st_next.timer_clk              = 1'b0;
      st_next.stretching             = 1'b0;
      st_next.program_select_pin     = 1'b1;
      st_next.general_select_one_pin = 1'b1;
      st_next.general_select_two_pin = 1'b1;
      st_next.stretch_cfg            = GCS_REG_RESET;                    // [RL21]
      st_next.one_base               = GCS_REG_RESET;
      st_next.one_ctrl               = GCS_REG_RESET;                    // [RL21]
      st_next.two_base               = GCS_REG_RESET;
      st_next.two_ctrl               = GCS_REG_RESET;                    // [RL21]
      st_next.waitreq                = 1'b1;
      st_next.rdata                  = 32'h00000000;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign AVS_READDATA_O           = st_reg.rdata;
  assign AVS_WAITREQUEST_O        = st_reg.waitreq;
  assign E_CLK_O                  = st_reg.e_clk;
  assign TIMER_CLK_O              = st_reg.timer_clk;
  assign STRETCHING_O             = st_reg.stretching;
  assign PROGRAM_SELECT_PIN_O     = st_reg.program_select_pin;
  assign GENERAL_SELECT_ONE_PIN_O = st_reg.general_select_one_pin;
  assign GENERAL_SELECT_TWO_PIN_O = st_reg.general_select_two_pin;

endmodule : gcs_top

// ==== gcs_pkg.sv ====
package gcs_pkg;

  // ----------------------------------------------------------------
  // Register map (indices; byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [8:0] GCS_IDX_STRETCH  = 9'h05a;
  localparam logic [8:0] GCS_IDX_ONE_BASE = 9'h05c;
  localparam logic [8:0] GCS_IDX_ONE_CTRL = 9'h05d;
  localparam logic [8:0] GCS_IDX_TWO_BASE = 9'h05e;
  localparam logic [8:0] GCS_IDX_TWO_CTRL = 9'h05f;
  localparam logic [8:0] GCS_IDX_STATUS   = 9'h060;
  localparam int         GCS_ADDR_W       = 11;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int GCS_CTRL_TO_PROG = 7;
  localparam int GCS_CTRL_TO_TWO  = 6;
  localparam int GCS_CTRL_POL     = 5;
  localparam int GCS_CTRL_VALID   = 4;
  localparam int GCS_CTRL_SIZE_HI = 3;
  localparam int GCS_STR_IO_LO    = 6;
  localparam int GCS_STR_ONE_LO   = 4;
  localparam int GCS_STR_TWO_LO   = 2;
  localparam int GCS_STR_PROG_LO  = 0;
  localparam logic [7:0] GCS_REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Size codes and address bit range
  // ----------------------------------------------------------------
  localparam logic [3:0] GCS_SZ_OFF    = 4'h0;
  localparam logic [3:0] GCS_SZ_4K     = 4'h2;
  localparam logic [3:0] GCS_SZ_512K   = 4'h9;
  localparam logic [3:0] GCS_SZ_WIN1   = 4'ha;
  localparam logic [3:0] GCS_SZ_WIN2   = 4'hb;
  localparam int         GCS_BASE_LSB  = 11;
  localparam int         GCS_CPU_MSB   = 15;
  localparam int         GCS_XADDR_W   = 19;
  localparam int         GCS_SZ_SHIFT  = 10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {GCS_PH_LOW, GCS_PH_HIGH} gcs_phase_t;

  typedef struct packed {
    logic [15:0]            cpu_addr;
    logic [GCS_XADDR_W-1:0] exp_addr;
    logic                   win_one_hit;
    logic                   win_two_hit;
    logic                   program_hit;
    logic                   io_hit;
    logic                   general_over_program_priority;
    logic                   sel_one_expansion_basing;
    logic                   sel_two_expansion_basing;
  } gcs_decode_t;

  typedef struct packed {
    gcs_phase_t  phase;
    logic [2:0]  hold_cnt;
    logic        cycle_on;
    logic        e_clk;
    logic        timer_clk;
    logic        stretching;
    logic        program_select_pin;
    logic        general_select_one_pin;
    logic        general_select_two_pin;
    logic [7:0]  stretch_cfg;
    logic [7:0]  one_base;
    logic [7:0]  one_ctrl;
    logic [7:0]  two_base;
    logic [7:0]  two_ctrl;
    logic        waitreq;
    logic [31:0] rdata;
  } gcs_state_t;

endpackage : gcs_pkg

// ==== gcs_bus_partner.sv ====
`timescale 1ns/1ps

module gcs_bus_partner (
  // Clock, reset and bus strobe
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       e_clk_i,
  // Select pins as the external devices see them
  input  wire logic       prog_pin_i,
  input  wire logic       two_pin_i,
  input  wire logic       one_pin_i,
  input  wire logic       two_pol_i,
  input  wire logic       one_pol_i,
  // Summary of the last completed bus cycle
  output logic [2:0]      hi_seen_o,
  output logic [2:0]      lo_seen_o,
  output logic [3:0]      hi_len_o
);
  // A device only reacts to what it saw during the cycle, so activity is gathered per phase
  logic [2:0] act, hi_reg, lo_reg;
  logic [3:0] len_reg;
  logic       e_reg;

  assign act = {~prog_pin_i, two_pin_i == two_pol_i, one_pin_i == one_pol_i};

  always_ff @(posedge clk_i) begin
    e_reg <= e_clk_i;
    if (rst_i) begin
      hi_reg  <= 3'h0;
      lo_reg  <= 3'h0;
      len_reg <= 4'h0;
    end else if (e_reg && !e_clk_i) begin
      hi_seen_o <= hi_reg;
      lo_seen_o <= lo_reg;
      hi_len_o  <= len_reg;
      hi_reg    <= 3'h0;
      lo_reg    <= act;
      len_reg   <= 4'h0;
    end else if (e_clk_i) begin
      hi_reg  <= hi_reg | act;
      len_reg <= len_reg + 4'h1;
    end else begin
      lo_reg <= lo_reg | act;
    end
  end
endmodule : gcs_bus_partner

// ==== gcs_assertions.sv ====
`timescale 1ns/1ps

module gcs_assertions (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  // Register bus handshake
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic AVS_WAITREQUEST_O,
  // Expansion bus outputs
  input wire logic E_CLK_O,
  input wire logic TIMER_CLK_O,
  input wire logic STRETCHING_O,
  input wire logic PROGRAM_SELECT_PIN_O,
  input wire logic GENERAL_SELECT_ONE_PIN_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);

  AST_TIMER_FREE: assert property (!$past(SRST_I) |-> TIMER_CLK_O != $past(TIMER_CLK_O))
    else $error("timer clock missed a toggle");
  AST_E_LOW_ONE: assert property ($fell(E_CLK_O) |=> E_CLK_O)
    else $error("E low phase not one cycle");
  AST_E_HIGH_BOUND: assert property ($rose(E_CLK_O) |-> ##[1:7] $fell(E_CLK_O))
    else $error("E high longer than three extra cycles");
  AST_STRETCH_IN_HIGH: assert property (STRETCHING_O |-> E_CLK_O && !$rose(E_CLK_O))
    else $error("stretch flag outside extended E high");
  AST_STRETCH_LEN: assert property ($rose(STRETCHING_O) |-> STRETCHING_O[*2] ##[1:5] $fell(STRETCHING_O))
    else $error("stretch length out of range");
  AST_STRETCH_END: assert property ($fell(STRETCHING_O) |-> $fell(E_CLK_O))
    else $error("stretch ended without E falling");
  AST_PROG_SYNC: assert property ($changed(PROGRAM_SELECT_PIN_O) |-> $fell(E_CLK_O))
    else $error("program select moved off the E edge");
  AST_WAIT_ONE: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low for more than one cycle");
  AST_WAIT_ANSWER: assert property (($rose(AVS_READ_I) || $rose(AVS_WRITE_I)) |=> !AVS_WAITREQUEST_O)
    else $error("register access not answered after one wait state");

  cover property ($rose(STRETCHING_O));
  cover property ($fell(PROGRAM_SELECT_PIN_O));
  cover property ($fell(GENERAL_SELECT_ONE_PIN_O));
endmodule : gcs_assertions

bind gcs_top gcs_assertions u_gcs_chk (
  .CLK_SYS_I(CLK_SYS_I), .SRST_I(SRST_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .E_CLK_O(E_CLK_O), .TIMER_CLK_O(TIMER_CLK_O),
  .STRETCHING_O(STRETCHING_O), .PROGRAM_SELECT_PIN_O(PROGRAM_SELECT_PIN_O),
  .GENERAL_SELECT_ONE_PIN_O(GENERAL_SELECT_ONE_PIN_O));

// ==== general_chip_select_and_stretch_test.sv ====
`timescale 1ns/1ps

module general_chip_select_and_stretch_test;
  import gcs_pkg::*;
  logic                  clk, srst, rd, wr, acc, wreq, e_clk, tmr, strt, pin_p, pin_1, pin_2;
  logic                  pol1, pol2;
  logic [GCS_ADDR_W-1:0] adr;
  logic [31:0]           wdat, rdat, got;
  logic [2:0]            hi_seen, lo_seen, rt, e1, e2;
  logic [3:0]            hi_len;
  logic [8:0]            regs [5];
  gcs_decode_t           dec;
  int                    err_total, cmp_count, c;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  gcs_top uut (.CLK_SYS_I(clk), .SRST_I(srst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq),
    .BUS_ACCESS_I(acc), .DECODE_I(dec), .E_CLK_O(e_clk), .TIMER_CLK_O(tmr),
    .STRETCHING_O(strt), .PROGRAM_SELECT_PIN_O(pin_p), .GENERAL_SELECT_ONE_PIN_O(pin_1),
    .GENERAL_SELECT_TWO_PIN_O(pin_2));

  gcs_bus_partner u_bus (.clk_i(clk), .rst_i(srst), .e_clk_i(e_clk), .prog_pin_i(pin_p),
    .two_pin_i(pin_2), .one_pin_i(pin_1), .two_pol_i(pol2), .one_pol_i(pol1),
    .hi_seen_o(hi_seen), .lo_seen_o(lo_seen), .hi_len_o(hi_len));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_up(input string what);
    err_total++;
    $display("unexpected %s: expected an answer, seen none", what);
    report_and_stop();
  endtask : give_up

  // Request is held until waitrequest is seen low, released on that same edge, then one idle edge follows
  task automatic bus(input logic w, input logic [8:0] idx, input logic [7:0] d);
    int i;
    adr  <= {idx, 2'h0};
    wdat <= {24'h0, d};
    rd   <= ~w;
    wr   <= w;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (wreq === 1'b0) break;
    end
    if (i == 20) give_up("register handshake");
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus

  // Decode inputs may change mid cycle, so only the third complete cycle is judged
  task automatic run(input logic [2:0] eh, input logic [2:0] el, input logic [3:0] len);
    int   i, f;
    logic p;
    f = 0;
    p = e_clk;
    for (i = 0; i < 200 && f < 3; i++) begin
      @(posedge clk);
      if (p === 1'b1 && e_clk === 1'b0) f++;
      p = e_clk;
    end
    if (f < 3) give_up("bus cycle");
    @(negedge clk);
    check("selects in E high", hi_seen, eh);
    check("selects in E low", lo_seen, el);
    check("E high length", hi_len, len);
    @(posedge clk);
  endtask : run

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    acc = 1'b0;
    adr = '0;
    wdat = '0;
    dec = '0;
    pol1 = 1'b0;
    pol2 = 1'b0;
    err_total = 0;
    cmp_count = 0;
    regs = '{GCS_IDX_STRETCH, GCS_IDX_ONE_BASE, GCS_IDX_ONE_CTRL, GCS_IDX_TWO_BASE, GCS_IDX_TWO_CTRL};
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    check("idle pins", {pin_p, pin_2, pin_1}, 32'h7);
    for (c = 0; c < 5; c++) begin
      bus(1'b0, regs[c], 8'h00);
      check("reset value", got, 32'h0);
      bus(1'b1, regs[c], 8'h3c);
      bus(1'b0, regs[c], 8'h00);
      check("readback", got, 32'h3c);
      bus(1'b1, regs[c], 8'h00);
    end
    bus(1'b1, 9'h001, 8'hff);
    bus(1'b0, 9'h001, 8'h00);
    check("unmapped read", got, 32'h0);
    $display("test registers done");
    acc <= 1'b1;
    dec.cpu_addr <= 16'h2800;
    bus(1'b1, GCS_IDX_ONE_BASE, 8'h05);
    bus(1'b1, GCS_IDX_ONE_CTRL, 8'h01);
    run(3'h1, 3'h0, 4'h1);
    dec.cpu_addr <= 16'h3000;
    run(3'h0, 3'h0, 4'h1);
    bus(1'b1, GCS_IDX_ONE_CTRL, 8'h36);
    pol1 <= 1'b1;
    dec.cpu_addr <= 16'hf000;
    run(3'h1, 3'h1, 4'h1);
    pol1 <= 1'b0;
    bus(1'b1, GCS_IDX_ONE_CTRL, 8'h00);
    bus(1'b1, GCS_IDX_TWO_BASE, 8'h07);
    bus(1'b1, GCS_IDX_TWO_CTRL, 8'h11);
    dec.cpu_addr <= 16'h3800;
    run(3'h2, 3'h2, 4'h1);
    bus(1'b1, GCS_IDX_TWO_CTRL, 8'h21);
    pol2 <= 1'b1;
    run(3'h2, 3'h0, 4'h1);
    pol2 <= 1'b0;
    bus(1'b1, GCS_IDX_TWO_CTRL, 8'h00);
    $display("test polarity and timing done");
    dec.sel_one_expansion_basing <= 1'b1;
    dec.exp_addr <= 19'h40000;
    bus(1'b1, GCS_IDX_ONE_BASE, 8'h80);
    bus(1'b1, GCS_IDX_ONE_CTRL, 8'h08);
    run(3'h1, 3'h0, 4'h1);
    dec.sel_two_expansion_basing <= 1'b1;
    bus(1'b1, GCS_IDX_TWO_BASE, 8'h80);
    bus(1'b1, GCS_IDX_TWO_CTRL, 8'h18);
    run(3'h3, 3'h2, 4'h1);
    bus(1'b1, GCS_IDX_TWO_CTRL, 8'h00);
    bus(1'b1, GCS_IDX_TWO_BASE, 8'h07);
    dec.sel_two_expansion_basing <= 1'b0;
    dec.exp_addr <= 19'h3ffff;
    run(3'h0, 3'h0, 4'h1);
    bus(1'b1, GCS_IDX_ONE_CTRL, 8'h0c);
    run(3'h1, 3'h0, 4'h1);
    dec.sel_one_expansion_basing <= 1'b0;
    dec.win_one_hit <= 1'b1;
    bus(1'b1, GCS_IDX_ONE_CTRL, 8'h0a);
    run(3'h1, 3'h0, 4'h1);
    dec.win_one_hit <= 1'b0;
    run(3'h0, 3'h0, 4'h1);
    dec.win_two_hit <= 1'b1;
    bus(1'b1, GCS_IDX_ONE_CTRL, 8'h0b);
    run(3'h1, 3'h0, 4'h1);
    dec.win_two_hit <= 1'b0;
    $display("test decode done");
    dec.cpu_addr <= 16'h2800;
    bus(1'b1, GCS_IDX_ONE_BASE, 8'h05);
    bus(1'b1, GCS_IDX_ONE_CTRL, 8'h01);
    for (c = 0; c < 4; c++) begin
      bus(1'b1, GCS_IDX_STRETCH, 8'(c * 16));
      run(3'h1, 3'h0, 4'(1 + 2 * c));
    end
    dec.cpu_addr <= 16'h3000;
    run(3'h0, 3'h0, 4'h1);
    dec.io_hit <= 1'b1;
    bus(1'b1, GCS_IDX_STRETCH, 8'hc0);
    run(3'h0, 3'h0, 4'h7);
    dec.io_hit <= 1'b0;
    dec.program_hit <= 1'b1;
    bus(1'b1, GCS_IDX_STRETCH, 8'h02);
    run(3'h4, 3'h4, 4'h5);
    $display("test stretch done");
    dec.cpu_addr <= 16'h2800;
    bus(1'b1, GCS_IDX_STRETCH, 8'h00);
    bus(1'b1, GCS_IDX_ONE_CTRL, 8'h11);
    run(3'h4, 3'h4, 4'h1);
    dec.general_over_program_priority <= 1'b1;
    run(3'h1, 3'h1, 4'h1);
    bus(1'b1, GCS_IDX_ONE_CTRL, 8'h51);
    run(3'h2, 3'h2, 4'h1);
    dec.general_over_program_priority <= 1'b0;
    run(3'h4, 3'h4, 4'h1);
    dec.program_hit <= 1'b0;
    for (c = 0; c < 8; c++) begin
      rt = 3'(c);
      e1 = {rt[1], rt[2] & ~rt[1] & ~rt[0], ~rt[1] & ~(rt[2] & ~rt[0])};
      e2 = {rt[0], ~rt[0], 1'b0};
      bus(1'b1, GCS_IDX_ONE_CTRL, {rt[1], rt[2], 6'h11});
      bus(1'b1, GCS_IDX_TWO_CTRL, {rt[0], 7'h11});
      dec.cpu_addr <= 16'h2800;
      run(e1, e1, 4'h1);
      dec.cpu_addr <= 16'h3800;
      run(e2, e2, 4'h1);
    end
    $display("test routing done");
    srst <= 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    bus(1'b0, GCS_IDX_ONE_CTRL, 8'h00);
    check("control after reset", got, 32'h0);
    $display("test second reset done");
    report_and_stop();
  end
endmodule : general_chip_select_and_stretch_test
